// >>> shared/rcf_pkg.sv
// package: register map, field positions and reset values for reset cause flags
package rcf_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0]  IDX_CAUSE     = 8'h8E;
   localparam logic [7:0]  IDX_CTRL      = 8'h8F;
   localparam logic [7:0]  IDX_IRQ_STAT  = 8'h90;
   localparam logic [7:0]  IDX_IRQ_MASK  = 8'h91;
   localparam logic [31:0] ADDR_CAUSE    = {22'h00_0000, IDX_CAUSE, 2'h0};
   localparam logic [31:0] ADDR_CTRL     = {22'h00_0000, IDX_CTRL, 2'h0};
   localparam logic [31:0] ADDR_IRQ_STAT = {22'h00_0000, IDX_IRQ_STAT, 2'h0};
   localparam logic [31:0] ADDR_IRQ_MASK = {22'h00_0000, IDX_IRQ_MASK, 2'h0};

   // reset cause register fields
   localparam int unsigned CAUSE_W      = 2;
   localparam int unsigned BIT_BROWNOUT = 0;
   localparam int unsigned BIT_POWERON  = 1;
   localparam logic [1:0]  CAUSE_RST    = 2'h1;

   // interrupt status and mask fields
   localparam int unsigned IRQ_W        = 3;
   localparam int unsigned BIT_EXTRST   = 2;
   localparam logic [2:0]  IRQ_RST      = 3'h0;

   // control register fields
   localparam int unsigned BIT_RCMODE   = 0;
   localparam logic        CTRL_RST     = 1'b0;

   // input synchroniser lanes
   localparam int unsigned SYNC_W       = 4;
   localparam int unsigned LANE_EXTRST  = 0;
   localparam int unsigned LANE_POWERON = 1;
   localparam int unsigned LANE_BROWN   = 2;
   localparam int unsigned LANE_BROWNOUT_DETECT_ENABLE   = 3;
   localparam logic [3:0]  SYNC_RST     = 4'h1;

   // instruction clock: output toggles every DIV_HALF rising oscillator edges
   localparam logic [0:0]  DIV_HALF_M1  = 1'h1;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'b0;
endpackage

// >>> shared/rcf_div_if.sv
// interface: control and result of the instruction clock divider
`timescale 1ns/1ps
interface rcf_div_if;
   logic enable;
   logic clkOut;
   modport ctrl (output enable, input clkOut);
   modport div  (input enable, output clkOut);
endinterface

// >>> rtl/rcf_clk_div.sv
// module: oscillator synchroniser and divide-by-four instruction clock
`timescale 1ns/1ps
module rcf_clk_div (
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic oscInput,
   rcf_div_if.div    dv
);
   logic       oscMeta;
   logic       oscSync;
   logic       oscLast;
   logic [0:0] cnt;
   logic       clkOut;
   logic       next_oscLast;
   logic [0:0] next_cnt;
   logic       next_clkOut;
   logic       oscRise;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         oscMeta <= 1'b0;
         oscSync <= 1'b0;
      end else begin
         oscMeta <= oscInput;
         oscSync <= oscMeta;
      end
   end

   assign oscRise = oscSync & ~oscLast;

   // two rising edges per half period give a quarter of the input rate
   always_comb begin
      next_oscLast = oscSync;
      next_cnt     = cnt;
      next_clkOut  = clkOut;
      if (!dv.enable) begin
         next_cnt    = 1'h0;
         next_clkOut = 1'b0;
      end else if (oscRise) begin
         if (cnt == rcf_pkg::DIV_HALF_M1) begin
            next_cnt    = 1'h0;
            next_clkOut = ~clkOut;
         end else begin
            next_cnt = cnt + 1'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         oscLast <= 1'b0;
         cnt     <= 1'h0;
         clkOut  <= 1'b0;
      end else begin
         oscLast <= next_oscLast;
         cnt     <= next_cnt;
         clkOut  <= next_clkOut;
      end
   end

   assign dv.clkOut = clkOut;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_div_toggle: assert property (
      dv.enable && oscRise && cnt == 1'h1 |=> clkOut != $past(clkOut))
      else $error("instruction clock missed its toggle");
   a_div_still: assert property (
      dv.enable && !oscRise |=> $stable(clkOut))
      else $error("instruction clock moved without an oscillator edge");
endmodule

// >>> rtl/rcf_top.sv
// module: reset cause flags with AHB-Lite registers and interrupt
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module rcf_top (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        externalResetN,
   input  wire logic        powerOnEvent,
   input  wire logic        brownoutEvent,
   input  wire logic        brownoutDetectEnable,
   input  wire logic        oscInput,
   output logic             instrClockOut,
   output logic             deviceReset,
   output logic             irq
);
   logic [rcf_pkg::SYNC_W-1:0]  syncMeta;
   logic [rcf_pkg::SYNC_W-1:0]  syncOut;
   logic [rcf_pkg::SYNC_W-1:0]  syncLast;
   logic                        extSync;
   logic                        bden;
   logic                        porHit;
   logic                        borHit;
   logic                        extHit;
   logic                        take;
   logic                        wrPend;
   logic [31:0]                 wrAddr;
   logic                        next_wrPend;
   logic [31:0]                 next_wrAddr;
   logic [31:0]                 next_hrdata;
   logic [rcf_pkg::CAUSE_W-1:0] cause;
   logic [rcf_pkg::CAUSE_W-1:0] next_cause;
   logic [rcf_pkg::IRQ_W-1:0]   irqStat;
   logic [rcf_pkg::IRQ_W-1:0]   irqMask;
   logic [rcf_pkg::IRQ_W-1:0]   next_irqStat;
   logic [rcf_pkg::IRQ_W-1:0]   next_irqMask;
   logic                        next_irq;
   logic                        rcMode;
   logic                        next_rcMode;
   logic                        next_deviceReset;
   logic                        wrCause;
   logic                        wrCtrl;
   logic                        wrStat;
   logic                        wrMask;

   rcf_div_if divBus ();

   rcf_clk_div u_div (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .oscInput (oscInput),
      .dv       (divBus.div)
   );

   // pin inputs pass two flip-flops before any logic
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         syncMeta <= rcf_pkg::SYNC_RST;
         syncOut  <= rcf_pkg::SYNC_RST;
         syncLast <= rcf_pkg::SYNC_RST;
      end else begin
         syncMeta <= {brownoutDetectEnable, brownoutEvent,
                      powerOnEvent, externalResetN};
         syncOut  <= syncMeta;
         syncLast <= syncOut;
      end
   end

   assign extSync = syncOut[rcf_pkg::LANE_EXTRST];
   assign bden    = syncOut[rcf_pkg::LANE_BROWNOUT_DETECT_ENABLE];
   assign porHit  = syncOut[rcf_pkg::LANE_POWERON] &
                    ~syncLast[rcf_pkg::LANE_POWERON];
   assign borHit  = syncOut[rcf_pkg::LANE_BROWN] &
                    ~syncLast[rcf_pkg::LANE_BROWN];
   assign extHit  = ~extSync & syncLast[rcf_pkg::LANE_EXTRST];

   // bus: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = rcf_pkg::HRESP_OKAY;
   assign take      = hsel & (htrans == rcf_pkg::HTRANS_NONSEQ) & hready;

   assign wrCause = wrPend & (wrAddr == rcf_pkg::ADDR_CAUSE);
   assign wrCtrl  = wrPend & (wrAddr == rcf_pkg::ADDR_CTRL);
   assign wrStat  = wrPend & (wrAddr == rcf_pkg::ADDR_IRQ_STAT);
   assign wrMask  = wrPend & (wrAddr == rcf_pkg::ADDR_IRQ_MASK);

   always_comb begin
      next_wrPend = take & hwrite;
      next_wrAddr = take ? haddr : wrAddr;
      next_hrdata = 32'h0000_0000;
      if (take && !hwrite) begin
         case (haddr)
            rcf_pkg::ADDR_CAUSE:
               next_hrdata = {30'h0000_0000, cause};
            rcf_pkg::ADDR_CTRL:
               next_hrdata = {31'h0000_0000, rcMode};
            rcf_pkg::ADDR_IRQ_STAT:
               next_hrdata = {29'h0000_0000, irqStat};
            rcf_pkg::ADDR_IRQ_MASK:
               next_hrdata = {29'h0000_0000, irqMask};
            default:
               next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wrPend <= 1'b0;
         wrAddr <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
      end else begin
         wrPend <= next_wrPend;
         wrAddr <= next_wrAddr;
         hrdata <= next_hrdata;
      end
   end

   // cause flags: software write stores, reset events clear and win
   always_comb begin
      next_cause = cause;
      if (wrCause) begin
         next_cause = hwdata[rcf_pkg::CAUSE_W-1:0];
      end
      if (porHit) begin
         next_cause[rcf_pkg::BIT_POWERON] = 1'b0;
      end
      if (borHit && bden) begin
         next_cause[rcf_pkg::BIT_BROWNOUT] = 1'b0;
      end
   end

   // flags survive an external reset so software can tell resets apart
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cause <= rcf_pkg::CAUSE_RST;
      end else begin
         cause <= next_cause;
      end
   end

   // external reset clears control state and drives device reset
   always_comb begin
      next_deviceReset = ~extSync;
      next_rcMode      = rcMode;
      if (!extSync) begin
         next_rcMode = rcf_pkg::CTRL_RST;
      end else if (wrCtrl) begin
         next_rcMode = hwdata[rcf_pkg::BIT_RCMODE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         deviceReset <= 1'b1;
         rcMode      <= rcf_pkg::CTRL_RST;
      end else begin
         deviceReset <= next_deviceReset;
         rcMode      <= next_rcMode;
      end
   end

   assign divBus.enable = rcMode;
   assign instrClockOut = divBus.clkOut;

   // interrupt: sticky events, write one to clear, set wins
   always_comb begin
      next_irqStat = irqStat;
      next_irqMask = irqMask;
      if (wrStat) begin
         next_irqStat = irqStat & ~hwdata[rcf_pkg::IRQ_W-1:0];
      end
      if (wrMask) begin
         next_irqMask = hwdata[rcf_pkg::IRQ_W-1:0];
      end
      if (porHit) begin
         next_irqStat[rcf_pkg::BIT_POWERON] = 1'b1;
      end
      if (borHit && bden) begin
         next_irqStat[rcf_pkg::BIT_BROWNOUT] = 1'b1;
      end
      if (extHit) begin
         next_irqStat[rcf_pkg::BIT_EXTRST] = 1'b1;
      end
      next_irq = |(next_irqStat & next_irqMask);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irqStat <= rcf_pkg::IRQ_RST;
         irqMask <= rcf_pkg::IRQ_RST;
         irq     <= 1'b0;
      end else begin
         irqStat <= next_irqStat;
         irqMask <= next_irqMask;
         irq     <= next_irq;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_rd_cause;
      take && !hwrite && haddr == rcf_pkg::ADDR_CAUSE;
   endsequence
   sequence s_wr_cause;
      take && hwrite && haddr == rcf_pkg::ADDR_CAUSE;
   endsequence

   a_cause_upper_zero: assert property (
      s_rd_cause |=> hrdata[31:2] == 30'h0000_0000 &&
                     hrdata[1:0] == $past(cause))
      else $error("cause read shows wrong bits");
   a_por_clears: assert property (
      porHit |=> !cause[rcf_pkg::BIT_POWERON])
      else $error("power-on flag not cleared");
   a_bor_clears: assert property (
      borHit && bden |=> !cause[rcf_pkg::BIT_BROWNOUT])
      else $error("brown-out flag not cleared");
   a_bor_disabled: assert property (
      borHit && !bden && !wrCause && !porHit |=> $stable(cause))
      else $error("disabled detector changed brown-out flag");
   a_ext_reset: assert property (
      !extSync |=> deviceReset && !rcMode ##1 !divBus.clkOut)
      else $error("external reset did not reset the device");
   a_sw_sets: assert property (
      s_wr_cause ##1 (hwdata[1] && !porHit) |=> cause[rcf_pkg::BIT_POWERON])
      else $error("software write did not set power-on flag");
   a_flag_holds: assert property (
      cause[rcf_pkg::BIT_POWERON] && !porHit && !wrCause
      |=> cause[rcf_pkg::BIT_POWERON])
      else $error("power-on flag dropped without cause");
   a_irq_sticky: assert property (
      extHit && irqMask[rcf_pkg::BIT_EXTRST] && !wrMask
      ##1 !wrStat && !wrMask |-> irq ##1 irq)
      else $error("external reset interrupt not raised");
endmodule

// >>> verif/rcf_top_tb.sv
// testbench: register, event, reset pin and clock output checks
`timescale 1ns/1ps
module rcf_top_tb;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        externalResetN = 1'b1;
   logic        powerOnEvent = 1'b0;
   logic        brownoutEvent = 1'b0;
   logic        brownoutDetectEnable = 1'b1;
   logic        oscInput = 1'b0;
   logic        instrClockOut;
   logic        deviceReset;
   logic        irq;
   logic [31:0] rdCap;
   logic [31:0] q;
   logic        rdyCap;
   logic        ic1;
   logic        ic2;
   logic        oscRun = 1'b0;
   logic [1:0]  oscCnt = 2'h0;
   int          fails = 0;
   int          n_tests = 0;

   always #12.5 ref_clk = ~ref_clk;

   // values the master sees at each rising edge
   always @(posedge ref_clk) begin
      rdCap <= hrdata;
      rdyCap <= hreadyout;
      ic1 <= instrClockOut;
      ic2 <= ic1;
   end

   // oscillator: half period of four reference cycles
   always @(posedge ref_clk) begin
      if (oscRun) begin
         oscCnt <= oscCnt + 2'h1;
         if (oscCnt == 2'h3) begin
            oscInput <= ~oscInput;
         end
      end
   end

   rcf_top uut (
      .ref_clk              (ref_clk),
      .srst                 (srst),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (3'h2),
      .hwdata               (hwdata),
      .hready               (hreadyout),
      .hreadyout            (hreadyout),
      .hresp                (hresp),
      .hrdata               (hrdata),
      .externalResetN       (externalResetN),
      .powerOnEvent         (powerOnEvent),
      .brownoutEvent        (brownoutEvent),
      .brownoutDetectEnable (brownoutDetectEnable),
      .oscInput             (oscInput),
      .instrClockOut        (instrClockOut),
      .deviceReset          (deviceReset),
      .irq                  (irq)
   );

   task automatic report_and_stop;
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         cyc(1);
         k++;
      end while (rdyCap !== 1'b1 && k < 16);
      if (rdyCap !== 1'b1) begin
         fails++;
         report_and_stop();
      end
   endtask

   // one single word transfer; read data lands in q
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= rcf_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = rdCap;
   endtask

   task automatic wait_rise(output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (!(ic1 === 1'b1 && ic2 === 1'b0) && n < 80);
      if (n >= 80) begin
         fails++;
         report_and_stop();
      end
   endtask

   task automatic t_reset;
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause at reset", 32'h0000_0001, q);
      chk("deviceReset idle", 32'h0000_0000, {31'h0, deviceReset});
      chk("hresp okay", 32'h0000_0000, {31'h0, hresp});
      xfer(1'b0, 32'h0000_0100, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, q);
   endtask

   task automatic t_cause_write;
      xfer(1'b1, rcf_pkg::ADDR_CAUSE, 32'hFFFF_FFFF);
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause all ones", 32'h0000_0003, q);
   endtask

   task automatic t_power;
      xfer(1'b1, rcf_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
      powerOnEvent <= 1'b1;
      cyc(6);
      powerOnEvent <= 1'b0;
      chk("irq power-on", 32'h0000_0001, {31'h0, irq});
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause power-on", 32'h0000_0001, q);
      xfer(1'b0, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("status power-on", 32'h0000_0002, q);
      xfer(1'b1, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
      cyc(2);
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      xfer(1'b1, rcf_pkg::ADDR_CAUSE, 32'h0000_0003);
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause set again", 32'h0000_0003, q);
   endtask

   task automatic t_brown;
      brownoutEvent <= 1'b1;
      cyc(6);
      brownoutEvent <= 1'b0;
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause brown-out", 32'h0000_0002, q);
      xfer(1'b0, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("status brown-out", 32'h0000_0001, q);
      xfer(1'b1, rcf_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      cyc(2);
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      xfer(1'b1, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      xfer(1'b1, rcf_pkg::ADDR_CAUSE, 32'h0000_0003);
      brownoutDetectEnable <= 1'b0;
      cyc(3);
      brownoutEvent <= 1'b1;
      cyc(6);
      brownoutEvent <= 1'b0;
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause detector off", 32'h0000_0003, q);
      xfer(1'b0, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("status detector off", 32'h0000_0000, q);
      brownoutDetectEnable <= 1'b1;
      cyc(3);
   endtask

   task automatic t_ext;
      xfer(1'b1, rcf_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
      externalResetN <= 1'b0;
      cyc(4);
      chk("deviceReset low pin", 32'h0000_0001, {31'h0, deviceReset});
      chk("irq pin reset", 32'h0000_0001, {31'h0, irq});
      externalResetN <= 1'b1;
      cyc(4);
      chk("deviceReset released", 32'h0000_0000, {31'h0, deviceReset});
      xfer(1'b0, rcf_pkg::ADDR_CAUSE, 32'h0000_0000);
      chk("cause kept", 32'h0000_0003, q);
      xfer(1'b0, rcf_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk("status pin reset", 32'h0000_0004, q);
   endtask

   task automatic t_clk;
      int n;
      xfer(1'b1, rcf_pkg::ADDR_CTRL, 32'h0000_0001);
      oscRun <= 1'b1;
      wait_rise(n);
      wait_rise(n);
      chk("instr clock period", 32'd32, n);
      xfer(1'b1, rcf_pkg::ADDR_CTRL, 32'h0000_0000);
      cyc(4);
      chk("instr clock off", 32'h0000_0000, {31'h0, instrClockOut});
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      cyc(1);
      t_reset();
      t_cause_write();
      t_power();
      t_brown();
      t_ext();
      t_clk();
      report_and_stop();
   end
endmodule
